// file: plth_target.sv
// Local target handshake, address decode flags and local master grant logic
module plth_target #(
  parameter int unsigned WIDE_LOCAL_BUS = 0
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // PCI engine side
  input  wire plth_pkg::plth_pci_req_t pci_req,
  input  wire logic                   exprom_match,
  input  wire logic                   pci_data_phase,
  input  wire logic [31:0]            pci_wr_data,
  input  wire logic                   pci_wr_valid,
  output logic                        pci_wr_ready,
  output plth_pkg::plth_term_t        pci_term,
  input  wire logic                   pci_bus_grant,
  // Local target side
  input  wire logic                   target_abort_request_n,
  input  wire logic                   target_disconnect_request_n,
  input  wire logic                   target_side_ready_n,
  output logic                        target_read_not_write,
  output logic                        target_access_active_n,
  output logic [3:0]                  target_command_code,
  output logic                        target_word_transfer_n,
  output logic                        target_low_word_transfer_n,
  output logic [31:0]                 local_data_out,
  output logic [5:0]                  base_range_match,
  output logic                        cap_space_match,
  // Local master request/grant
  input  wire logic                   master_narrow_request_n,
  input  wire logic                   master_wide_request_n,
  output logic                        master_bus_granted_n
);
  import plth_pkg::*;

  function automatic logic cap_hit(input plth_pci_req_t r);
    logic cfg;
    cfg = (r.command == PLTH_CMD_CFG_READ) || (r.command == PLTH_CMD_CFG_WRITE);
    return r.active && cfg && (r.address[7:0] >= PLTH_CAP_LOW) && (r.address[7:0] <= PLTH_CAP_HIGH);
  endfunction

  // Decode and direction state
  logic        rnw_reg, rnw_next;
  logic        acc_reg, acc_next;
  logic [3:0]  cmd_reg, cmd_next;
  logic [5:0]  bar_reg, bar_next;
  logic        cap_reg, cap_next;
  logic        xfer_reg, xfer_next;
  plth_term_t  term_reg, term_next;

  always_comb begin
    bar_next  = pci_req.active ? pci_req.bar_match : 6'h00;
    cap_next  = cap_hit(pci_req);
    acc_next  = (|bar_next) || (pci_req.active && exprom_match) || cap_next
                || (pci_req.active && pci_req.command == PLTH_CMD_SPECIAL);
    rnw_next  = pci_req.active ? pci_req.is_read : rnw_reg;
    cmd_next  = pci_req.active ? pci_req.command : cmd_reg;
    term_next.abort      = acc_reg && !target_abort_request_n;
    term_next.disconnect = acc_reg && !target_disconnect_request_n;
    // Read strobe: engine samples local input while back end is ready
    xfer_next = acc_reg && rnw_reg && pci_data_phase && !target_side_ready_n;
  end

  // Two-entry write buffer; the back end stalls by withholding ready
  logic [31:0] buf_mem [PLTH_BUF_DEPTH];
  logic        wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic [31:0] dout_reg, dout_next;
  logic        wstb_reg, wstb_next;
  logic        push, pop;

  always_comb begin
    pci_wr_ready = (cnt_reg != 2'h2);
    push      = pci_wr_valid && pci_wr_ready;
    pop       = (cnt_reg != 2'h0) && !target_side_ready_n && !rnw_reg;
    wp_next   = push ? ~wp_reg : wp_reg;
    rp_next   = pop ? ~rp_reg : rp_reg;
    cnt_next  = cnt_reg + {1'b0, push} - {1'b0, pop};
    dout_next = pop ? buf_mem[rp_reg] : dout_reg;
    wstb_next = pop;
  end

  always_ff @(posedge clock) begin
    if (push) begin
      buf_mem[wp_reg] <= pci_wr_data;
    end
  end

  // Grant handshake
  plth_gnt_state_t gst_reg, gst_next;
  logic            req_any;

  always_comb begin
    req_any  = !master_narrow_request_n || !master_wide_request_n;
    gst_next = gst_reg;
    unique case (gst_reg)
      PLTH_IDLE: begin
        if (req_any) begin
          gst_next = PLTH_REQ;
        end
      end
      PLTH_REQ: begin
        if (pci_bus_grant) begin
          gst_next = PLTH_GRANTED;
        end else if (!req_any) begin
          gst_next = PLTH_IDLE;
        end
      end
      PLTH_GRANTED: begin
        if (!pci_bus_grant) begin
          gst_next = PLTH_IDLE;
        end
      end
      default: gst_next = PLTH_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rnw_reg  <= 1'b0;
      acc_reg  <= 1'b0;
      cmd_reg  <= 4'h0;
      bar_reg  <= 6'h00;
      cap_reg  <= 1'b0;
      xfer_reg <= 1'b0;
      term_reg <= '0;
      wp_reg   <= 1'b0;
      rp_reg   <= 1'b0;
      cnt_reg  <= 2'h0;
      dout_reg <= 32'h0000_0000;
      wstb_reg <= 1'b0;
      gst_reg  <= PLTH_IDLE;
    end else begin
      rnw_reg  <= rnw_next;
      acc_reg  <= acc_next;
      cmd_reg  <= cmd_next;
      bar_reg  <= bar_next;
      cap_reg  <= cap_next;
      xfer_reg <= xfer_next;
      term_reg <= term_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      cnt_reg  <= cnt_next;
      dout_reg <= dout_next;
      wstb_reg <= wstb_next;
      gst_reg  <= gst_next;
    end
  end

  logic xfer_any;
  assign xfer_any                   = xfer_reg || wstb_reg;
  assign target_read_not_write      = rnw_reg;
  assign target_access_active_n     = !acc_reg;
  assign target_command_code        = cmd_reg;
  assign base_range_match           = bar_reg;
  assign cap_space_match            = cap_reg;
  assign pci_term                   = term_reg;
  assign local_data_out             = dout_reg;
  // Only one strobe is live for a given bus width
  assign target_word_transfer_n     = !(xfer_any && WIDE_LOCAL_BUS == 0);
  assign target_low_word_transfer_n = !(xfer_any && WIDE_LOCAL_BUS != 0);
  assign master_bus_granted_n       = !(gst_reg == PLTH_GRANTED && pci_bus_grant);

  AST_ACCESS_FOLLOWS_BAR: assert property (@(posedge clock) disable iff (!rst_n)
    (pci_req.active && |pci_req.bar_match) |=> !target_access_active_n)
    else $error("access not active after base range match");
  AST_SPECIAL_ACCESS: assert property (@(posedge clock) disable iff (!rst_n)
    (pci_req.active && pci_req.command == PLTH_CMD_SPECIAL) |=> !target_access_active_n)
    else $error("access not active in special cycle");
  AST_DIRECTION: assert property (@(posedge clock) disable iff (!rst_n)
    pci_req.active |=> (target_read_not_write == $past(pci_req.is_read)))
    else $error("direction does not follow transaction");
  AST_ABORT: assert property (@(posedge clock) disable iff (!rst_n)
    (!target_access_active_n && !target_abort_request_n) |=> pci_term.abort)
    else $error("abort request not passed on");
  AST_DISCONNECT: assert property (@(posedge clock) disable iff (!rst_n)
    (!target_access_active_n && !target_disconnect_request_n) |=> pci_term.disconnect)
    else $error("disconnect request not passed on");
  AST_CAP_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    cap_space_match |-> $past(pci_req.address[7:0]) >= PLTH_CAP_LOW)
    else $error("capability match below 40h");
  AST_WRITE_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    (!target_read_not_write && !target_side_ready_n && cnt_reg != 2'h0) |=> xfer_any)
    else $error("no strobe for buffered write word");
  AST_GRANT_NEEDS_REQ: assert property (@(posedge clock) disable iff (!rst_n)
    (gst_reg == PLTH_IDLE) |-> master_bus_granted_n)
    else $error("grant without request");
  AST_GRANT_DROP: assert property (@(posedge clock) disable iff (!rst_n)
    !pci_bus_grant |-> master_bus_granted_n)
    else $error("grant held without bus grant");
  AST_STROBE_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
    !(!target_word_transfer_n && !target_low_word_transfer_n))
    else $error("both strobes active");
  AST_BAR_MATCH: assert property (@(posedge clock) disable iff (!rst_n)
    pci_req.active |=> (base_range_match == $past(pci_req.bar_match)))
    else $error("base range match does not follow request");
  AST_CAP_HIT: assert property (@(posedge clock) disable iff (!rst_n)
    (pci_req.active && (pci_req.command == PLTH_CMD_CFG_READ || pci_req.command == PLTH_CMD_CFG_WRITE)
     && pci_req.address[7:0] >= PLTH_CAP_LOW) |=> cap_space_match)
    else $error("capability match missing for upper config offset");
  AST_GRANT_HELD: assert property (@(posedge clock) disable iff (!rst_n)
    (gst_reg == PLTH_REQ && pci_bus_grant) ##1 pci_bus_grant |-> !master_bus_granted_n)
    else $error("grant not passed to local master");
  AST_READ_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    (!target_access_active_n && target_read_not_write && pci_data_phase && !target_side_ready_n)
    |=> xfer_any)
    else $error("no strobe for sampled read word");
endmodule

// file: plth_pkg.sv
// Package for the local target handshake and master request/grant block
package plth_pkg;
  localparam int unsigned PLTH_BAR_COUNT     = 6;
  localparam logic [7:0]  PLTH_CAP_LOW       = 8'h40;
  localparam logic [7:0]  PLTH_CAP_HIGH      = 8'hFF;
  localparam logic [3:0]  PLTH_CMD_SPECIAL   = 4'h1;
  localparam logic [3:0]  PLTH_CMD_CFG_READ  = 4'hA;
  localparam logic [3:0]  PLTH_CMD_CFG_WRITE = 4'hB;
  localparam int unsigned PLTH_BUF_DEPTH     = 2;

  // PCI-side request as seen by this block
  typedef struct packed {
    logic        active;
    logic        is_read;
    logic [3:0]  command;
    logic [31:0] address;
    logic [5:0]  bar_match;
  } plth_pci_req_t;

  // Termination requests to the PCI engine
  typedef struct packed {
    logic abort;
    logic disconnect;
  } plth_term_t;

  typedef enum logic [1:0] {
    PLTH_IDLE    = 2'b00,
    PLTH_REQ     = 2'b01,
    PLTH_GRANTED = 2'b11
  } plth_gnt_state_t;
endpackage

// file: plth_backend.sv
// Behavioural back-end model for the local target side
module plth_backend (
  // Clock
  input  wire logic        clock,
  // Bench commands
  input  wire logic        stall,
  input  wire logic        abort_cmd,
  input  wire logic        disc_cmd,
  // Local target side
  input  wire logic        target_access_active_n,
  input  wire logic [3:0]  target_command_code,
  input  wire logic        target_read_not_write,
  input  wire logic        target_word_transfer_n,
  input  wire logic [31:0] local_data_out,
  output logic             target_side_ready_n,
  output logic             target_abort_request_n,
  output logic             target_disconnect_request_n
);
  logic [31:0] got_q[$];
  logic [3:0]  cmd_seen;
  int          n_reads = 0;
  initial begin
    target_side_ready_n = 1'b1;
    target_abort_request_n = 1'b1;
    target_disconnect_request_n = 1'b1;
    cmd_seen = 4'h0;
  end
  always @(posedge clock) begin
    // Write data is new in the strobe cycle and held after it, so capture it there
    // Read strobes carry no output data, so only count them
    if (target_word_transfer_n === 1'b0 && target_read_not_write === 1'b0) got_q.push_back(local_data_out);
    if (target_word_transfer_n === 1'b0 && target_read_not_write === 1'b1) n_reads++;
    if (target_access_active_n === 1'b0) cmd_seen <= target_command_code;
    target_side_ready_n <= stall;
    // Terminations only make sense inside an access
    target_abort_request_n <= !(abort_cmd && !target_access_active_n);
    target_disconnect_request_n <= !(disc_cmd && !target_access_active_n);
  end
endmodule

// file: tb_pci_local_target_handshake.sv
// Testbench for the local target handshake and master grant block
module tb_pci_local_target_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  import plth_pkg::*;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  plth_pci_req_t pci_req = '0;
  logic          rom = 1'b0, phase = 1'b0, wvalid = 1'b0, grant = 1'b0;
  logic          nar_n = 1'b1, wide_n = 1'b1, stall = 1'b1, ab = 1'b0, dc = 1'b0;
  logic [31:0]   wdata = '0, dout;
  plth_term_t    term;
  logic          wready, ab_n, dc_n, rdy_n, rnw, acc_n, xf_n, lxf_n, cap, gnt_n;
  logic [3:0]    cmd;
  logic [5:0]    bar;
  logic          xf_w_n, lxf_w_n;
  int            n_fail = 0, checks = 0, cycles = 0;

  plth_target #(.WIDE_LOCAL_BUS(0)) i_dut (.clock, .rst_n, .pci_req, .exprom_match(rom),
    .pci_data_phase(phase), .pci_wr_data(wdata), .pci_wr_valid(wvalid), .pci_wr_ready(wready),
    .pci_term(term), .pci_bus_grant(grant), .target_abort_request_n(ab_n),
    .target_disconnect_request_n(dc_n), .target_side_ready_n(rdy_n), .target_read_not_write(rnw),
    .target_access_active_n(acc_n), .target_command_code(cmd), .target_word_transfer_n(xf_n),
    .target_low_word_transfer_n(lxf_n), .local_data_out(dout), .base_range_match(bar),
    .cap_space_match(cap), .master_narrow_request_n(nar_n), .master_wide_request_n(wide_n),
    .master_bus_granted_n(gnt_n));
  // Second copy with a 64-bit local bus, watched only on its strobes
  plth_target #(.WIDE_LOCAL_BUS(1)) i_dut_wide (.clock, .rst_n, .pci_req, .exprom_match(rom),
    .pci_data_phase(phase), .pci_wr_data(wdata), .pci_wr_valid(wvalid), .pci_wr_ready(),
    .pci_term(), .pci_bus_grant(grant), .target_abort_request_n(ab_n),
    .target_disconnect_request_n(dc_n), .target_side_ready_n(rdy_n), .target_read_not_write(),
    .target_access_active_n(), .target_command_code(), .target_word_transfer_n(xf_w_n),
    .target_low_word_transfer_n(lxf_w_n), .local_data_out(), .base_range_match(),
    .cap_space_match(), .master_narrow_request_n(nar_n), .master_wide_request_n(wide_n),
    .master_bus_granted_n());
  plth_backend i_model (.clock, .stall, .abort_cmd(ab), .disc_cmd(dc), .target_access_active_n(acc_n),
    .target_command_code(cmd), .target_read_not_write(rnw), .target_word_transfer_n(xf_n), .local_data_out(dout),
    .target_side_ready_n(rdy_n), .target_abort_request_n(ab_n), .target_disconnect_request_n(dc_n));

  initial forever #25 clock = ~clock;
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs about 70 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic req(logic a, logic r, logic [3:0] c, logic [31:0] ad, logic [5:0] b);
    pci_req = '{a, r, c, ad, b};
    step(2);
  endtask
  task automatic t_decode;
    req(1, 1, 4'h6, 32'h0000_1000, 6'h20);
    chk("bar", bar, 6'h20);
    chk("access", acc_n, 0);
    chk("rnw", rnw, 1);
    chk("cmd", cmd, 4'h6);
    chk("cmd seen", i_model.cmd_seen, 4'h6);
    rom = 1'b1;
    req(1, 0, 4'h7, 32'h0000_0000, 6'h00);
    chk("access rom", acc_n, 0);
    chk("rnw", rnw, 0);
    chk("bar", bar, 0);
    rom = 1'b0;
    req(1, 0, PLTH_CMD_SPECIAL, 32'h0000_0000, 6'h00);
    chk("access special", acc_n, 0);
    req(1, 1, PLTH_CMD_CFG_READ, 32'h0000_0040, 6'h00);
    chk("cap 40", cap, 1);
    chk("access cap", acc_n, 0);
    req(1, 0, PLTH_CMD_CFG_WRITE, 32'h0000_00FF, 6'h00);
    chk("cap ff", cap, 1);
    req(1, 1, PLTH_CMD_CFG_READ, 32'h0000_003F, 6'h00);
    chk("cap 3f", cap, 0);
    chk("access none", acc_n, 1);
    $display("decode test done");
  endtask
  task automatic t_term;
    ab = 1'b1;
    req(1, 1, 4'h6, 32'h0000_0000, 6'h01);
    step(2);
    chk("abort", term.abort, 1);
    ab = 1'b0;
    dc = 1'b1;
    step(4);
    chk("abort off", term.abort, 0);
    chk("disconnect", term.disconnect, 1);
    dc = 1'b0;
    step(4);
    chk("disconnect off", term.disconnect, 0);
    $display("termination test done");
  endtask
  task automatic t_read;
    phase = 1'b1;
    stall = 1'b0;
    for (int i = 0; i < 8 && xf_n !== 1'b0; i++) step(1);
    chk("read strobe", xf_n, 0);
    chk("low strobe", lxf_n, 1);
    chk("wide low strobe", lxf_w_n, 0);
    chk("wide single strobe", xf_w_n, 1);
    phase = 1'b0;
    step(3);
    chk("read strobe off", xf_n, 1);
    chk("read strobes", i_model.n_reads, 1);
    stall = 1'b1;
    $display("read test done");
  endtask
  task automatic t_write;
    req(1, 0, 4'h7, 32'h0000_0000, 6'h01);
    wvalid = 1'b1;
    wdata = 32'hA5A5_0001;
    step(1);
    wdata = 32'hA5A5_0002;
    step(1);
    wvalid = 1'b0;
    chk("buffer full", wready, 0);
    stall = 1'b0;
    step(8);
    chk("words", i_model.got_q.size(), 2);
    chk("word 0", i_model.got_q[0], 32'hA5A5_0001);
    chk("word 1", i_model.got_q[1], 32'hA5A5_0002);
    chk("buffer free", wready, 1);
    chk("low strobe", lxf_n, 1);
    stall = 1'b1;
    req(0, 0, 4'h0, 32'h0000_0000, 6'h00);
    $display("write test done");
  endtask
  task automatic t_grant;
    grant = 1'b1;
    step(2);
    chk("grant unasked", gnt_n, 1);
    grant = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) nar_n = 1'b0;
      else wide_n = 1'b0;
      step(1);
      grant = 1'b1;
      step(1);
      chk("granted", gnt_n, 0);
      step(1);
      chk("grant held", gnt_n, 0);
      grant = 1'b0;
      #1;
      chk("grant dropped", gnt_n, 1);
      nar_n = 1'b1;
      wide_n = 1'b1;
      step(2);
    end
    $display("grant test done");
  endtask
  task automatic t_reset;
    req(1, 1, 4'h6, 32'h0000_0000, 6'h01);
    chk("access before reset", acc_n, 0);
    rst_n = 1'b0;
    step(1);
    chk("access in reset", acc_n, 1);
    chk("bar in reset", bar, 6'h00);
    chk("rnw in reset", rnw, 0);
    chk("ready in reset", wready, 1);
    rst_n = 1'b1;
    step(2);
    chk("access after reset", acc_n, 0);
    chk("bar after reset", bar, 6'h01);
    req(0, 0, 4'h0, 32'h0000_0000, 6'h00);
    $display("reset test done");
  endtask
  initial begin
    step(5);
    rst_n = 1'b1;
    step(1);
    t_decode();
    t_term();
    t_read();
    t_write();
    t_grant();
    t_reset();
    stop_test();
  end
endmodule
